/* File: src/gpcw_pkg.sv */
`default_nettype none

package gpcw_pkg;

	// ----------------------------------------------------------------
	// Widths and positions
	// ----------------------------------------------------------------
	localparam int GPCW_WIDTH = 8;
	localparam int GPCW_CHG_LO = 4;
	localparam int GPCW_CHG_BITS = 4;
	localparam int GPCW_SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] GPCW_DIR_RST = 8'hff;
	localparam logic [7:0] GPCW_LATCH_RST = 8'h00;
	localparam logic GPCW_PU_N_RST = 1'b1;
	localparam logic [3:0] GPCW_REF_RST = 4'h0;
	localparam logic [1:0] GPCW_SETTLE_RST = 2'h0;
	// One cycle more than the synchroniser depth, so the last load of the
	// reference sees real pin levels rather than the synchroniser's zeros.
	localparam logic [1:0] GPCW_SETTLE_DONE = 2'h3;

	// Set to one to model the variant that may lose a change arriving
	// in the read quarter of a port read.
	localparam logic GPCW_MISS_AT_READ = 1'b0;

	// ----------------------------------------------------------------
	// Instruction cycle quarters
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_FETCH,
		PH_READ,
		PH_EXEC,
		PH_WRITE
	} gpcw_phase_e;

endpackage

`default_nettype wire

/* File: src/gpcw_port.sv */
`default_nettype none

module gpcw_port import gpcw_pkg::*; (
	input wire logic clk, // core clock, 250 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] pad_in, // pin levels
	output logic [7:0] pad_out, // pin output levels
	output logic [7:0] pad_oe, // pin driver enable, high drives
	output logic [7:0] pullup_on, // weak pull-up enable per pin
	input wire logic port_rd_req, // read of port_data
	output logic [7:0] port_rd_data, // value captured by the read
	input wire logic port_wr_req, // write of port_data
	input wire logic [7:0] port_wr_data, // new output latch value
	input wire logic dir_wr_req, // write of port_direction
	input wire logic [7:0] dir_wr_data, // one = input, zero = output
	input wire logic pu_wr_req, // write of pullup_enable_n
	input wire logic pullup_enable_n, // zero enables the pull-ups
	input wire logic flag_wr_req, // write of port_change_flag
	input wire logic flag_wr_data, // written flag value
	output logic port_change_flag, // interrupt_control bit 0
	output logic wake_req, // asks the core to leave sleep
	output logic read_phase, // second quarter of the cycle
	output logic write_phase // fourth quarter of the cycle
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		gpcw_phase_e phase;
		logic [7:0] latch;
		logic [7:0] dir;
		logic pu_n;
		logic [3:0] ref_val;
		logic flag;
		logic [7:0] rd_data;
		logic [1:0] settle;
	} gpcw_state_s;

	gpcw_state_s st_q;
	gpcw_state_s st_d;
	logic [7:0] pins;
	logic [3:0] miss;
	logic mismatch;
	logic rd_now;
	logic wr_now;
	logic settled;

	gpcw_sync #(
		.W(GPCW_WIDTH)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in(pad_in),
		.sync_out(pins)
	);

	// ----------------------------------------------------------------
	// Change detection
	// ----------------------------------------------------------------
	assign read_phase = (st_q.phase == PH_READ);
	assign write_phase = (st_q.phase == PH_WRITE);
	assign rd_now = read_phase && port_rd_req;
	assign wr_now = write_phase && port_wr_req;
	// No change can be seen until the reference holds synchronised pin
	// levels, which keeps a reset from looking like a key press.
	assign settled = (st_q.settle == GPCW_SETTLE_DONE);
	// Output pins drop out of the comparison.
	assign miss = (pins[7:GPCW_CHG_LO] ^ st_q.ref_val)
		& st_q.dir[7:GPCW_CHG_LO];
	assign mismatch = settled && (|miss);

	always_comb begin
		st_d = st_q;
		case (st_q.phase)
			PH_FETCH: st_d.phase = PH_READ;
			PH_READ: st_d.phase = PH_EXEC;
			PH_EXEC: st_d.phase = PH_WRITE;
			PH_WRITE: st_d.phase = PH_FETCH;
			default: st_d.phase = PH_FETCH;
		endcase
		// Until the synchroniser holds real pin levels the reference
		// just tracks them, so reset does not fake a change.
		if (!settled) begin
			st_d.settle = st_q.settle + 2'h1;
			st_d.ref_val = pins[7:GPCW_CHG_LO];
		end
		if (rd_now) begin
			st_d.rd_data = pins;
			st_d.ref_val = pins[7:GPCW_CHG_LO];
		end
		if (wr_now) begin
			st_d.latch = port_wr_data;
			st_d.ref_val = pins[7:GPCW_CHG_LO];
		end
		if (write_phase && dir_wr_req) begin
			st_d.dir = dir_wr_data;
		end
		if (write_phase && pu_wr_req) begin
			st_d.pu_n = pullup_enable_n;
		end
		if (write_phase && flag_wr_req) begin
			st_d.flag = flag_wr_data;
		end
		// Setting wins over a software clear, so the flag cannot be
		// cleared while the mismatch lasts.
		if (mismatch && !(GPCW_MISS_AT_READ && rd_now)) begin
			st_d.flag = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q.phase <= PH_FETCH;
			st_q.latch <= GPCW_LATCH_RST;
			st_q.dir <= GPCW_DIR_RST;
			st_q.pu_n <= GPCW_PU_N_RST;
			st_q.ref_val <= GPCW_REF_RST;
			st_q.flag <= 1'b0;
			st_q.rd_data <= GPCW_LATCH_RST;
			st_q.settle <= GPCW_SETTLE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Pins and outputs
	// ----------------------------------------------------------------
	assign pad_out = st_q.latch;
	assign pad_oe = ~st_q.dir;
	assign pullup_on = {8{~st_q.pu_n}} & st_q.dir;
	assign port_rd_data = st_q.rd_data;
	assign port_change_flag = st_q.flag;
	// Wake-up is the flag itself, so it stays up until software clears the flag
	// while no upper input pin differs from the reference.
	assign wake_req = st_q.flag;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// All checks but the reset one are off while reset is high, so they
	// see only cycles in which the quarters run.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_dir_write: assert property (
		write_phase && dir_wr_req |=> pad_oe == ~$past(dir_wr_data))
		else $error("direction write did not reach driver enable");

	chk_out_drive: assert property (
		wr_now |=> pad_out == $past(port_wr_data) ##3
		pad_out == $past(port_wr_data, 4))
		else $error("output latch not driven on the pin");

	chk_pullup_out: assert property (
		(pullup_on & pad_oe) == 8'h00)
		else $error("pull-up enabled on an output pin");

	chk_pullup_on: assert property (
		write_phase && pu_wr_req && !pullup_enable_n
		|=> pullup_on == ~pad_oe)
		else $error("cleared control did not enable pull-ups");

	chk_phase_order: assert property (
		read_phase |=> !read_phase && !write_phase ##1 write_phase
		##1 !read_phase ##1 read_phase)
		else $error("read and write quarters out of order");

	chk_access_refresh: assert property (
		rd_now |=> st_q.ref_val == $past(pins[7:4]))
		else $error("read did not refresh the reference");

	chk_write_refresh: assert property (
		wr_now |=> st_q.ref_val == $past(pins[7:4]))
		else $error("write did not refresh the reference");

	chk_read_data: assert property (
		rd_now |=> port_rd_data == $past(pins))
		else $error("read data not captured in read quarter");

	chk_mismatch_sets: assert property (
		mismatch && !(GPCW_MISS_AT_READ && rd_now) |=> port_change_flag)
		else $error("mismatch failed to set the flag");

	chk_out_excluded: assert property (
		settled && !port_change_flag && (&pad_oe[7:4])
		&& !(write_phase && (flag_wr_req || dir_wr_req))
		|=> !port_change_flag)
		else $error("output pin raised the change flag");

	chk_flag_wake: assert property (
		$rose(port_change_flag) |-> wake_req ##1 wake_req
		|| !port_change_flag)
		else $error("flag did not request wake-up");

	chk_sync_delay: assert property (
		settled |-> pins == $past(pad_in, 2))
		else $error("pins not delayed by two flops");

	chk_settle_quiet: assert property (
		!settled && !(write_phase && flag_wr_req)
		|=> !port_change_flag)
		else $error("flag raised before the pins had settled");

	chk_flag_clear: assert property (
		write_phase && flag_wr_req && !flag_wr_data && !mismatch
		|=> !port_change_flag)
		else $error("flag clear did not hold without a mismatch");

	chk_reset_pullups: assert property (
		disable iff (1'b0)
		rst |=> pullup_on == 8'h00 && !port_change_flag)
		else $error("reset left pull-ups or the flag on");

	cov_flag_set: cover property ($rose(port_change_flag));
	cov_clear_lost: cover property (mismatch && write_phase
		&& flag_wr_req && !flag_wr_data);
	cov_ack: cover property (rd_now ##[1:8]
		(write_phase && flag_wr_req && !flag_wr_data)
		##1 !port_change_flag);
	cov_pullups: cover property (pullup_on != 8'h00);

endmodule

`default_nettype wire

/* File: src/gpcw_sync.sv */
`default_nettype none

module gpcw_sync import gpcw_pkg::*; #(
	parameter int W = 8
) (
	input wire logic clk, // core clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [W-1:0] async_in, // raw pin levels
	output logic [W-1:0] sync_out // levels after two flops
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} gpcw_sync_s;

	gpcw_sync_s st_q;
	gpcw_sync_s st_d;

	// The first stage feeds only the second one.
	always_comb begin
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.stable;

endmodule

`default_nettype wire

/* File: verification/gpcw_pins.sv */
`default_nettype none

module gpcw_pins (
	input wire logic clk, // core clock
	input wire logic [7:0] pad_out, // device output levels
	input wire logic [7:0] pad_oe, // device driver enables
	input wire logic [7:0] pullup_on, // device pull-ups
	input wire logic [7:0] ext_val, // level the keypad drives
	input wire logic [7:0] ext_en, // keypad drives the pin
	output logic [7:0] pad_in // resolved pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_q;
	// ----------------------------------------------------------------
	// Pin resolution
	// ----------------------------------------------------------------
	// A pin that nobody drives or pulls flips every cycle, so a floating
	// input can never pass for a steady level.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pullup_on[i])
				pad_in[i] = 1'b1;
			else
				pad_in[i] = ~last_q[i];
		end
	end
	always_ff @(posedge clk) begin
		last_q <= pad_in;
	end
endmodule

`default_nettype wire

/* File: verification/tb_gpio_port_change_wake.sv */
`default_nettype none

module tb_gpio_port_change_wake;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst;
	logic rd = 1'b0, wr = 1'b0, dw = 1'b0, pw = 1'b0, fw = 1'b0;
	logic pun = 1'b1, fd = 1'b0;
	logic [7:0] wd = 8'h00, dd = 8'hff, ev = 8'h00, ee = 8'hff;
	logic [7:0] pin, pout, poe, pu, rdat, d, w;
	logic flag, wake, rph, wph;
	int failures = 0, comparisons = 0;
	int seed = 32'hd28fdda4;

	always #2 clk = ~clk;

	gpcw_pins pins (.clk(clk), .pad_out(pout), .pad_oe(poe),
		.pullup_on(pu), .ext_val(ev), .ext_en(ee), .pad_in(pin));

	gpcw_port dut (.clk(clk), .rst(rst), .pad_in(pin), .pad_out(pout),
		.pad_oe(poe), .pullup_on(pu), .port_rd_req(rd),
		.port_rd_data(rdat), .port_wr_req(wr), .port_wr_data(wd),
		.dir_wr_req(dw), .dir_wr_data(dd), .pu_wr_req(pw),
		.pullup_enable_n(pun), .flag_wr_req(fw), .flag_wr_data(fd),
		.port_change_flag(flag), .wake_req(wake), .read_phase(rph),
		.write_phase(wph));

	function automatic logic [7:0] pin_of(logic [7:0] dr, lt, ex);
		return (~dr & lt) | (dr & ex);
	endfunction

	// Quarter flags {write, read} seen k cycles after reset has ended.
	function automatic logic [7:0] phase_of(int k);
		return (k == 0) ? 8'h01 : ((k == 2) ? 8'h02 : 8'h00);
	endfunction

	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask

	// Holds reset for eight cycles, then checks what it leaves behind;
	// used at the start and again in mid-run with pull-ups enabled.
	task automatic reset_run();
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("oe_rst", 8'h00, poe);
		chk("pu_rst", 8'h00, pu);
		chk("flag_rst", 8'h00, {7'h0, flag});
		chk("wake_rst", 8'h00, {7'h0, wake});
		for (int k = 0; k < 4; k++) begin
			chk("phase", phase_of(k), {6'h0, wph, rph});
			@(negedge clk);
		end
		chk("flag_settle", 8'h00, {7'h0, flag});
	endtask

	// Kind 0 reads, 1 writes the latch, 2 direction, 3 pull-up, 4 flag.
	task automatic acc(int k, logic [7:0] v);
		int n = 0;
		@(negedge clk);
		while (((k == 0) ? rph : wph) !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		case (k)
			0: rd = 1'b1;
			1: begin wr = 1'b1; wd = v; end
			2: begin dw = 1'b1; dd = v; end
			3: begin pw = 1'b1; pun = v[0]; end
			default: begin fw = 1'b1; fd = v[0]; end
		endcase
		@(negedge clk);
		{rd, wr, dw, pw, fw} = 5'h00;
		repeat (2) @(negedge clk);
	endtask

	task automatic results();
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		results();
	end

	initial begin
		reset_run();
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			w = 8'($random(seed));
			acc(2, d);
			acc(1, w);
			acc(3, i[0] ? 8'h00 : 8'h01);
			ev = 8'($random(seed));
			repeat (3) @(negedge clk);
			acc(0, 8'h00);
			chk("oe", ~d, poe);
			chk("out", w, pout);
			chk("pu", d & {8{i[0]}}, pu);
			chk("rd", pin_of(d, w, ev), rdat);
		end
		// Upper pins as outputs take no part in the comparison.
		acc(2, 8'h0f);
		acc(0, 8'h00);
		acc(4, 8'h00);
		ev = ev ^ 8'hf0;
		acc(1, 8'ha0);
		repeat (6) @(negedge clk);
		chk("flag_out", 8'h00, {7'h0, flag});
		acc(2, 8'hff);
		acc(0, 8'h00);
		acc(4, 8'h00);
		ev = ev ^ 8'h20;
		repeat (6) @(negedge clk);
		chk("flag_set", 8'h01, {7'h0, flag});
		chk("wake", 8'h01, {7'h0, wake});
		acc(4, 8'h00);
		chk("flag_hold", 8'h01, {7'h0, flag});
		acc(0, 8'h00);
		acc(4, 8'h00);
		chk("flag_clr", 8'h00, {7'h0, flag});
		chk("rd_chg", ev, rdat);
		// The keypad lets go of the upper pins; the pull-ups hold them high.
		ee = 8'h0f;
		acc(0, 8'h00);
		chk("rd_pull", {4'hf, ev[3:0]}, rdat);
		// Reset in mid-run must drop the pull-ups and raise no false change.
		ee = 8'hff;
		reset_run();
		results();
	end
endmodule

`default_nettype wire
